// ===== rtl/bsl_pkg.sv
package bsl_pkg;

    // Internal reset length in input clocks after the reset pin is released
    localparam int RESET_WAIT_DEFAULT = 750000;
    localparam int RESET_CNT_W        = 20;

    // Image memory depth in address bits
    localparam int MEM_AW_DEFAULT = 10;
    localparam int WORD_W         = 32;

    // Trailer value that turns the CRC check off
    localparam logic [31:0] CRC_SKIP_MARKER = 32'h0D15_AB1E;
    // CRC-32 polynomial, start value and final inversion
    localparam logic [31:0] CRC_POLY  = 32'h04C1_1DB7;
    localparam logic [31:0] CRC_INIT  = 32'hFFFF_FFFF;
    localparam logic [31:0] CRC_XOROUT = 32'hFFFF_FFFF;

    // User ID field positions and the security bit that forces OTP boot
    localparam int SEC_OTP_BOOT_BIT = 5;
    localparam int SEC_USER_ID_LSB  = 22;
    localparam int SEC_USER_ID_MSB  = 31;

    // Test port value layout
    localparam int ID_VERSION_LSB = 28;
    localparam int ID_PART_LSB    = 12;
    localparam int ID_MANUF_LSB   = 1;
    localparam int UC_USER_ID_LSB = 22;

    // Boot source codes
    localparam logic [2:0] SRC_NONE    = 3'h0;
    localparam logic [2:0] SRC_LINK    = 3'h1;
    localparam logic [2:0] SRC_SPI     = 3'h2;
    localparam logic [2:0] SRC_CHANEND = 3'h3;
    localparam logic [2:0] SRC_OTP     = 3'h4;

    // Straps codes on the three boot source pins
    localparam logic [2:0] STRAP_LINK_RELAY  = 3'h2;
    localparam logic [2:0] STRAP_SPI_RELAY   = 3'h3;
    localparam logic [2:0] STRAP_LINKS_INDEP = 3'h6;
    localparam logic [2:0] STRAP_SPI_INDEP   = 3'h7;

    // Loader states, Gray coded along the boot path
    typedef enum logic [3:0] {
        ST_HOLD  = 4'h0,
        ST_WAIT  = 4'h1,
        ST_SEL   = 4'h3,
        ST_LEN   = 4'h2,
        ST_PROG  = 4'h6,
        ST_TRAIL = 4'h7,
        ST_CHECK = 4'h5,
        ST_RUN   = 4'h4,
        ST_JTAG  = 4'hC,
        ST_FAIL  = 4'hD
    } bsl_state_t;

endpackage : bsl_pkg

// ===== rtl/bsl_image_mem.sv
`timescale 1ns/1ps

// Program store for the loaded image; read data come out of a register
module bsl_image_mem #(
    parameter int AW = 10,
    parameter int DW = 32
) (
    input  wire logic          core_clk,
    input  wire logic          wr_en,
    input  wire logic [AW-1:0] wr_addr,
    input  wire logic [DW-1:0] wr_data,
    input  wire logic          rd_en,
    input  wire logic [AW-1:0] rd_addr,
    output logic      [DW-1:0] rd_data
);

    logic [DW-1:0] mem_array [0:(1<<AW)-1];

    // Write port
    always_ff @(posedge core_clk)
    begin
        if (wr_en)
            mem_array[wr_addr] <= wr_data;
    end

    // Registered read port
    always_ff @(posedge core_clk)
    begin
        if (rd_en)
            rd_data <= mem_array[rd_addr];
    end

endmodule : bsl_image_mem

// ===== rtl/bsl_loader.sv
`timescale 1ns/1ps

module bsl_loader #(
    parameter int          RESET_WAIT_CYCLES = bsl_pkg::RESET_WAIT_DEFAULT,
    parameter int          MEM_AW            = bsl_pkg::MEM_AW_DEFAULT,
    parameter logic [3:0]  ID_VERSION        = 4'h1,        // Arbitrary value
    parameter logic [15:0] ID_PART           = 16'h00A5,    // Arbitrary value
    parameter logic [10:0] ID_MANUF          = 11'h05A,     // Arbitrary value
    parameter logic [21:0] SILICON_REV       = 22'h00_0001  // Arbitrary value
) (
    input  wire logic                     core_clk,
    input  wire logic                     rst,
    input  wire logic                     chip_reset_low,
    input  wire logic                     clock_speed_strap_lo,
    input  wire logic                     clock_speed_strap_hi,
    input  wire logic [2:0]               boot_source_straps,
    input  wire logic [31:0]              security_config,
    input  wire logic                     otp_programmed,
    input  wire logic                     gpio_oe_n_core,
    input  wire logic                     byte_valid,
    input  wire logic [7:0]               byte_data,
    output logic                          byte_ready,
    input  wire logic                     tap_capture,
    input  wire logic                     tap_sel_usercode,
    output logic      [31:0]              tap_data,
    output logic                          gpio_oe_n,
    output logic                          gpio_pull_en,
    output logic                          core_reset_active,
    output logic                          boot_clock_valid,
    output logic      [1:0]               boot_clock_sel,
    output logic      [2:0]               first_tile_source,
    output logic      [2:0]               second_tile_source,
    output logic                          links_enable,
    output logic                          jtag_boot_wait,
    output logic                          strap_reserved,
    output logic                          crc_checked,
    output logic                          crc_skipped,
    output logic                          crc_error,
    output logic                          program_start,
    output logic      [31:0]              image_words,
    input  wire logic                     mem_rd_en,
    input  wire logic [MEM_AW-1:0]        mem_rd_addr,
    output logic      [31:0]              mem_rd_data
);

    localparam logic [bsl_pkg::RESET_CNT_W-1:0] WAIT_LAST =
        bsl_pkg::RESET_CNT_W'(RESET_WAIT_CYCLES - 1);

    // One byte of CRC-32, most significant bit first
    function automatic logic [31:0] crc_byte(input logic [31:0] crc_in, input logic [7:0] data);
        logic [31:0] c;
        c = crc_in ^ {data, 24'h00_0000};
        for (int i = 0; i < 8; i++)
            c = c[31] ? ((c << 1) ^ bsl_pkg::CRC_POLY) : (c << 1);
        return c;
    endfunction : crc_byte

    bsl_pkg::bsl_state_t state_reg;
    bsl_pkg::bsl_state_t state_next;

    logic [bsl_pkg::RESET_CNT_W-1:0] wait_cnt_reg;
    logic [31:0]                     word_reg;
    logic [1:0]                      lane_reg;
    logic [31:0]                     len_reg;
    logic [31:0]                     word_cnt_reg;
    logic [31:0]                     crc_reg;
    logic [31:0]                     trailer_reg;
    logic [2:0]                      straps_reg;
    logic                            otp_mode_reg;
    logic [1:0]                      clk_sel_reg;
    logic                            pull_en_reg;
    logic                            oe_n_reg;
    logic [2:0]                      src0_reg;
    logic [2:0]                      src1_reg;
    logic                            links_reg;
    logic                            chk_reg;
    logic                            skip_reg;
    logic                            err_reg;
    logic                            start_reg;
    logic [31:0]                     tap_reg;

    // Reset request from either the core reset or the external pin
    wire        hold_req   = rst | ~chip_reset_low;
    wire        byte_take  = byte_valid & byte_ready;
    wire        word_done  = byte_take & (lane_reg == 2'd3);
    wire [31:0] word_full  = {byte_data, word_reg[31:8]};
    wire        wait_done  = (wait_cnt_reg == WAIT_LAST);
    wire        otp_forced = security_config[bsl_pkg::SEC_OTP_BOOT_BIT];
    wire        jtag_only  = (straps_reg[1:0] == 2'b00);
    wire        strap_rsvd = (straps_reg[1:0] == 2'b01);
    wire        last_word  = (word_cnt_reg == len_reg - 32'd1);
    wire        crc_match  = ((crc_reg ^ bsl_pkg::CRC_XOROUT) == trailer_reg);
    wire        is_skip    = (trailer_reg == bsl_pkg::CRC_SKIP_MARKER);
    wire        mem_wr     = (state_reg == bsl_pkg::ST_PROG) & word_done &
                             (word_cnt_reg < 32'(1 << MEM_AW));

    // Test port values
    wire [9:0]  user_id    = otp_programmed ?
                             security_config[bsl_pkg::SEC_USER_ID_MSB:bsl_pkg::SEC_USER_ID_LSB] :
                             10'h000;
    wire [31:0] idcode_val = (32'(ID_VERSION) << bsl_pkg::ID_VERSION_LSB) |
                             (32'(ID_PART) << bsl_pkg::ID_PART_LSB) |
                             (32'(ID_MANUF) << bsl_pkg::ID_MANUF_LSB) |
                             32'h0000_0001;
    wire [31:0] usercode_val = (32'(user_id) << bsl_pkg::UC_USER_ID_LSB) |
                               32'(SILICON_REV);

    // Handshake toward the byte source
    assign byte_ready = (state_reg == bsl_pkg::ST_LEN) |
                        (state_reg == bsl_pkg::ST_PROG) |
                        (state_reg == bsl_pkg::ST_TRAIL);

    // Next state of the boot sequence
    always_comb
    begin
        state_next = state_reg;
        case (state_reg)
            bsl_pkg::ST_HOLD:
                state_next = bsl_pkg::ST_WAIT;
            bsl_pkg::ST_WAIT:
                if (wait_done)
                    state_next = bsl_pkg::ST_SEL;
            bsl_pkg::ST_SEL:
                if (otp_mode_reg)
                    state_next = bsl_pkg::ST_LEN;
                else if (jtag_only)
                    state_next = bsl_pkg::ST_JTAG;
                else if (strap_rsvd)
                    state_next = bsl_pkg::ST_FAIL;
                else
                    state_next = bsl_pkg::ST_LEN;
            bsl_pkg::ST_LEN:
                if (word_done)
                    state_next = (word_full == 32'h0000_0000) ? bsl_pkg::ST_TRAIL : bsl_pkg::ST_PROG;
            bsl_pkg::ST_PROG:
                if (word_done && last_word)
                    state_next = bsl_pkg::ST_TRAIL;
            bsl_pkg::ST_TRAIL:
                if (word_done)
                    state_next = bsl_pkg::ST_CHECK;
            bsl_pkg::ST_CHECK:
                if (is_skip || crc_match)
                    state_next = bsl_pkg::ST_RUN;
                else
                    state_next = bsl_pkg::ST_FAIL;
            bsl_pkg::ST_RUN:
                state_next = bsl_pkg::ST_RUN;
            bsl_pkg::ST_JTAG:
                state_next = bsl_pkg::ST_JTAG;
            bsl_pkg::ST_FAIL:
                state_next = bsl_pkg::ST_FAIL;
            default:
                state_next = bsl_pkg::ST_HOLD;
        endcase
    end

    // State register
    always_ff @(posedge core_clk)
    begin
        if (hold_req)
            state_reg <= bsl_pkg::ST_HOLD;
        else
            state_reg <= state_next;
    end

    // Internal reset counter
    always_ff @(posedge core_clk)
    begin
        if (hold_req || state_reg != bsl_pkg::ST_WAIT)
            wait_cnt_reg <= '0;
        else if (!wait_done)
            wait_cnt_reg <= wait_cnt_reg + 1'b1;
    end

    // Pin drive and pull control
    always_ff @(posedge core_clk)
    begin
        if (hold_req)
        begin
            oe_n_reg    <= 1'b1;
            pull_en_reg <= 1'b0;
        end
        else
        begin
            if (state_reg == bsl_pkg::ST_WAIT && wait_done)
                pull_en_reg <= 1'b1;
            oe_n_reg <= (state_reg == bsl_pkg::ST_HOLD || state_reg == bsl_pkg::ST_WAIT) ?
                        1'b1 : gpio_oe_n_core;
        end
    end

    // Straps and security bit caught as the internal reset ends
    always_ff @(posedge core_clk)
    begin
        if (hold_req)
        begin
            straps_reg   <= 3'h0;
            otp_mode_reg <= 1'b0;
            clk_sel_reg  <= 2'h0;
        end
        else if (state_reg == bsl_pkg::ST_WAIT && wait_done)
        begin
            straps_reg   <= boot_source_straps;
            otp_mode_reg <= otp_forced;
            clk_sel_reg  <= {clock_speed_strap_hi, clock_speed_strap_lo};
        end
    end

    // Boot source routing per tile
    always_ff @(posedge core_clk)
    begin
        if (hold_req)
        begin
            src0_reg  <= bsl_pkg::SRC_NONE;
            src1_reg  <= bsl_pkg::SRC_NONE;
            links_reg <= 1'b0;
        end
        else if (state_reg == bsl_pkg::ST_SEL)
        begin
            links_reg <= 1'b0;
            if (otp_mode_reg)
            begin
                src0_reg <= bsl_pkg::SRC_OTP;
                src1_reg <= bsl_pkg::SRC_OTP;
            end
            else
            begin
                case (straps_reg)
                    bsl_pkg::STRAP_LINK_RELAY:
                    begin
                        src0_reg <= bsl_pkg::SRC_LINK;
                        src1_reg <= bsl_pkg::SRC_CHANEND;
                    end
                    bsl_pkg::STRAP_SPI_RELAY:
                    begin
                        src0_reg <= bsl_pkg::SRC_SPI;
                        src1_reg <= bsl_pkg::SRC_CHANEND;
                    end
                    bsl_pkg::STRAP_LINKS_INDEP:
                    begin
                        src0_reg  <= bsl_pkg::SRC_CHANEND;
                        src1_reg  <= bsl_pkg::SRC_CHANEND;
                        links_reg <= 1'b1;
                    end
                    bsl_pkg::STRAP_SPI_INDEP:
                    begin
                        src0_reg <= bsl_pkg::SRC_SPI;
                        src1_reg <= bsl_pkg::SRC_SPI;
                    end
                    default:
                    begin
                        src0_reg <= bsl_pkg::SRC_NONE;
                        src1_reg <= bsl_pkg::SRC_NONE;
                    end
                endcase
            end
        end
    end

    // Byte assembly, little endian within each word
    always_ff @(posedge core_clk)
    begin
        if (hold_req || state_reg == bsl_pkg::ST_SEL)
        begin
            word_reg <= 32'h0000_0000;
            lane_reg <= 2'd0;
        end
        else if (byte_take)
        begin
            word_reg <= word_full;
            lane_reg <= lane_reg + 2'd1;
        end
    end

    // Length, word count, running CRC and trailer
    always_ff @(posedge core_clk)
    begin
        if (hold_req || state_reg == bsl_pkg::ST_SEL)
        begin
            len_reg      <= 32'h0000_0000;
            word_cnt_reg <= 32'h0000_0000;
            crc_reg      <= bsl_pkg::CRC_INIT;
            trailer_reg  <= 32'h0000_0000;
        end
        else
        begin
            if (state_reg == bsl_pkg::ST_LEN && word_done)
                len_reg <= word_full;
            if (state_reg == bsl_pkg::ST_PROG && byte_take)
                crc_reg <= crc_byte(crc_reg, byte_data);
            if (state_reg == bsl_pkg::ST_PROG && word_done)
                word_cnt_reg <= word_cnt_reg + 32'd1;
            if (state_reg == bsl_pkg::ST_TRAIL && word_done)
                trailer_reg <= word_full;
        end
    end

    // Check results and program start
    always_ff @(posedge core_clk)
    begin
        if (hold_req)
        begin
            chk_reg   <= 1'b0;
            skip_reg  <= 1'b0;
            err_reg   <= 1'b0;
            start_reg <= 1'b0;
        end
        else
        begin
            start_reg <= 1'b0;
            if (state_reg == bsl_pkg::ST_CHECK)
            begin
                skip_reg  <= is_skip;
                chk_reg   <= ~is_skip;
                err_reg   <= ~is_skip & ~crc_match;
                start_reg <= is_skip | crc_match;
            end
        end
    end

    // Test port data captured on request
    always_ff @(posedge core_clk)
    begin
        if (rst)
            tap_reg <= 32'h0000_0000;
        else if (tap_capture)
            tap_reg <= tap_sel_usercode ? usercode_val : idcode_val;
    end

    bsl_image_mem #(
        .AW (MEM_AW),
        .DW (bsl_pkg::WORD_W)
    ) u_mem (
        .core_clk (core_clk),
        .wr_en    (mem_wr),
        .wr_addr  (word_cnt_reg[MEM_AW-1:0]),
        .wr_data  (word_full),
        .rd_en    (mem_rd_en),
        .rd_addr  (mem_rd_addr),
        .rd_data  (mem_rd_data)
    );

    // Output assignments
    assign tap_data           = tap_reg;
    assign gpio_oe_n          = oe_n_reg;
    assign gpio_pull_en       = pull_en_reg;
    assign core_reset_active  = (state_reg == bsl_pkg::ST_HOLD) | (state_reg == bsl_pkg::ST_WAIT);
    assign boot_clock_valid   = ~core_reset_active;
    assign boot_clock_sel     = clk_sel_reg;
    assign first_tile_source  = src0_reg;
    assign second_tile_source = src1_reg;
    assign links_enable       = links_reg;
    assign jtag_boot_wait     = (state_reg == bsl_pkg::ST_JTAG);
    assign strap_reserved     = (state_reg == bsl_pkg::ST_FAIL) & ~chk_reg;
    assign crc_checked        = chk_reg;
    assign crc_skipped        = skip_reg;
    assign crc_error          = err_reg;
    assign program_start      = start_reg;
    assign image_words        = len_reg;

endmodule : bsl_loader

// ===== test/bsl_loader_props.sv
`timescale 1ns/1ps

// Port checks on reset hold, boot source choice and image framing
module bsl_loader_props #(
    parameter int RESET_WAIT_CYCLES = 8
) (
    input wire logic        core_clk,
    input wire logic        rst,
    input wire logic        chip_reset_low,
    input wire logic [2:0]  boot_source_straps,
    input wire logic [31:0] security_config,
    input wire logic        gpio_oe_n_core,
    input wire logic        byte_valid,
    input wire logic        byte_ready,
    input wire logic        gpio_oe_n,
    input wire logic        gpio_pull_en,
    input wire logic        core_reset_active,
    input wire logic [2:0]  first_tile_source,
    input wire logic [2:0]  second_tile_source,
    input wire logic        links_enable,
    input wire logic        jtag_boot_wait,
    input wire logic        crc_checked,
    input wire logic        crc_skipped,
    input wire logic        crc_error,
    input wire logic        program_start,
    input wire logic [31:0] image_words
);
    int wait_cnt;
    int takes;

    // Held-reset cycles and image bytes taken since the last pin or core reset
    always_ff @(posedge core_clk)
    begin
        wait_cnt <= (rst || !chip_reset_low) ? 0 : wait_cnt + int'(core_reset_active);
        takes    <= (rst || !chip_reset_low) ? 0 : takes + int'(byte_valid && byte_ready);
    end

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);
    sequence s_boot; $fell(core_reset_active); endsequence
    sequence s_load; $rose(byte_ready); endsequence

    property p_hold; !chip_reset_low |=> gpio_oe_n && core_reset_active && !gpio_pull_en; endproperty
    a_hold: assert property (p_hold) else $error("pins driven or core run while reset pin low");
    property p_quiet; core_reset_active |-> gpio_oe_n && !gpio_pull_en && !byte_ready; endproperty
    a_quiet: assert property (p_quiet) else $error("pins active during internal reset");
    property p_oe; !core_reset_active && chip_reset_low |=> gpio_oe_n == $past(gpio_oe_n_core); endproperty
    a_oe: assert property (p_oe) else $error("pin enable not passed through after boot");
    property p_wait;
        s_boot |-> (wait_cnt inside {[RESET_WAIT_CYCLES:RESET_WAIT_CYCLES + 2]}) ##[0:1] gpio_pull_en;
    endproperty
    a_wait: assert property (p_wait) else $error("internal reset length or pulls wrong");
    property p_otp; s_load ##0 security_config[5] |-> first_tile_source == 3'h4 && second_tile_source == 3'h4; endproperty
    a_otp: assert property (p_otp) else $error("secure boot not taken from OTP");
    property p_relay; s_load ##0 (!security_config[5] && boot_source_straps[2:1] == 2'h1)
        |-> second_tile_source == 3'h3 && first_tile_source == (boot_source_straps[0] ? 3'h2 : 3'h1); endproperty
    a_relay: assert property (p_relay) else $error("relayed boot sources wrong");
    property p_links; s_load |-> links_enable == (!security_config[5] && boot_source_straps == 3'h6); endproperty
    a_links: assert property (p_links) else $error("link enable does not follow straps");
    property p_jtag; s_boot ##0 (!security_config[5] && boot_source_straps[1:0] == 2'h0)
        |-> ##[1:3] (jtag_boot_wait && !byte_ready); endproperty
    a_jtag: assert property (p_jtag) else $error("no test port wait with straps 00");
    property p_len; $fell(byte_ready) |-> takes == 4 * int'(image_words) + 8; endproperty
    a_len: assert property (p_len) else $error("image byte count differs from length word");
    property p_start; program_start |-> !crc_error && (crc_checked || crc_skipped); endproperty
    a_start: assert property (p_start) else $error("start without a passed or skipped check");
endmodule : bsl_loader_props

// ===== test/bsl_flash_model.sv
`timescale 1ns/1ps

// Boot flash or link peer: offers queued image bytes in order, with random stalls
module bsl_flash_model (
    input  wire logic       core_clk,
    input  wire logic       byte_ready,
    output logic            byte_valid = 1'b0,
    output logic      [7:0] byte_data = 8'h00
);
    logic [7:0] q[$];
    logic       more;

    // Hold a byte until taken; between bytes the data lines keep toggling
    always @(posedge core_clk)
    begin
        if (byte_valid && byte_ready)
            void'(q.pop_front());
        more = q.size() != 0 && $urandom_range(3) != 0;
        if (!byte_valid || byte_ready)
        begin
            byte_valid <= more;
            byte_data  <= more ? q[0] : ~byte_data;
        end
    end
endmodule : bsl_flash_model

// ===== test/bsl_loader_test.sv
`timescale 1ns/1ps
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin fail_count++; \
    $display("MISMATCH %0t got %h want %h", $time, a, b); end end

// Boots the loader through strap codes 0 to 4, 6 and 7 and reads the test port
module bsl_loader_test;
    logic        core_clk, rst, chip_reset_low, clock_speed_strap_lo, clock_speed_strap_hi, otp_programmed;
    logic        gpio_oe_n_core, byte_valid, byte_ready, tap_capture, tap_sel_usercode, gpio_oe_n, gpio_pull_en;
    logic        core_reset_active, boot_clock_valid, links_enable, jtag_boot_wait, strap_reserved, crc_checked;
    logic        crc_skipped, crc_error, program_start, mem_rd_en, cap_d, rd_d, fl_d;
    logic [1:0]  boot_clock_sel;
    logic [2:0]  boot_source_straps, first_tile_source, second_tile_source;
    logic [7:0]  byte_data;
    logic [9:0]  mem_rd_addr;
    logic [31:0] security_config, tap_data, image_words, mem_rd_data, word0;
    logic [63:0] got, note, exp_q[$];
    int          fail_count, samples_checked;

    bsl_loader #(.RESET_WAIT_CYCLES(8)) bsl_loader_i (.*);
    bsl_flash_model bsl_flash_model_i (.*);

    // 20 MHz clock
    initial
    begin
        core_clk = 1'b0;
        forever #25 core_clk = ~core_clk;
    end

    task automatic end_of_test;
        $display("checks %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : end_of_test

    // One word to the far side, low byte first
    task automatic push(input logic [31:0] w);
        for (int k = 0; k < 4; k++)
            bsl_flash_model_i.q.push_back(w[8*k +: 8]);
    endtask : push

    task automatic tap(input logic sel);
        @(posedge core_clk);
        tap_capture      <= 1'b1;
        tap_sel_usercode <= sel;
        exp_q.push_back(sel ? {32'h0000_0000, otp_programmed ? security_config[31:22] : 10'h000, 22'h00_0001}
                            : {32'h0000_0000, 4'h1, 16'h00A5, 11'h05A, 1'b1});
        @(posedge core_clk);
        tap_capture <= 1'b0;
    endtask : tap

    // Pin reset, straps, then an image of n words; mode 0 good CRC, 1 skip marker, 2 bad CRC
    task automatic boot(input logic [2:0] s, input logic sec, input int n, input int mode);
        logic [31:0] w, c;
        logic [6:0]  e;
        c = bsl_pkg::CRC_INIT;
        w = $urandom;
        w[5] = sec;
        e = sec ? {3'h4, 3'h4, 1'b0} : s == 3'h2 ? {3'h1, 3'h3, 1'b0} : s == 3'h3 ? {3'h2, 3'h3, 1'b0}
          : s == 3'h6 ? {3'h3, 3'h3, 1'b1} : {3'h2, 3'h2, 1'b0};
        @(posedge core_clk);
        chip_reset_low       <= 1'b0;
        boot_source_straps   <= s;
        security_config      <= w;
        clock_speed_strap_lo <= 1'($urandom);
        clock_speed_strap_hi <= 1'($urandom);
        repeat (3) @(posedge core_clk);
        chip_reset_low <= 1'b1;
        if (!sec && !s[1])
        begin
            repeat (16) @(posedge core_clk);
            `CHK({jtag_boot_wait, strap_reserved, byte_ready}, {!s[0], s[0], 1'b0})
        end
        else
        begin
            exp_q.push_back({18'h0_0000, 2'h3, clock_speed_strap_hi, clock_speed_strap_lo, e, mode == 1, mode == 2,
                             mode != 2, n[31:0]});
            push(n);
            for (int i = 0; i < n; i++)
            begin
                w = $urandom;
                word0 = (i == 0) ? w : word0;
                for (int b = 0; b < 32; b++)
                    c = (c[31] ^ w[b ^ 7]) ? ((c << 1) ^ bsl_pkg::CRC_POLY) : (c << 1);
                push(w);
            end
            w = c ^ bsl_pkg::CRC_XOROUT;
            push(mode == 1 ? bsl_pkg::CRC_SKIP_MARKER : mode == 2 ? w ^ 32'h0000_0001 : w);
            for (int i = 0; i < 600 && !(crc_checked | crc_skipped | crc_error); i++)
                @(posedge core_clk);
            @(posedge core_clk);
            `CHK(crc_checked | crc_skipped | crc_error, 1'b1)
        end
    endtask : boot

    // Each result is compared with the oldest note when it appears
    always @(posedge core_clk)
    begin
        cap_d          <= tap_capture;
        rd_d           <= mem_rd_en;
        fl_d           <= crc_checked | crc_skipped | crc_error;
        gpio_oe_n_core <= 1'($urandom);
        got = cap_d ? {32'h0000_0000, tap_data} : rd_d ? {32'h0000_0000, mem_rd_data}
            : {18'h0_0000, boot_clock_valid, gpio_pull_en, boot_clock_sel, first_tile_source, second_tile_source,
               links_enable, crc_skipped, crc_error, program_start, image_words};
        if (cap_d || rd_d || ((crc_checked | crc_skipped | crc_error) && !fl_d))
        begin
            note = exp_q.pop_front();
            `CHK(got, note)
        end
    end

    // Watchdog well beyond the expected run
    initial
    begin
        repeat (20000) @(posedge core_clk);
        fail_count++;
        end_of_test();
    end

    // Main sequence
    initial
    begin
        {rst, chip_reset_low} = 2'h3;
        {clock_speed_strap_lo, clock_speed_strap_hi, otp_programmed, tap_capture, tap_sel_usercode, mem_rd_en} = '0;
        boot_source_straps = 3'h0;
        security_config = 32'hFFC0_0000;
        mem_rd_addr = '0;
        void'($urandom(32'hee19_f22d));
        repeat (10) @(posedge core_clk);
        rst <= 1'b0;
        tap(1'b1);
        otp_programmed <= 1'b1;
        tap(1'b1);
        tap(1'b0);
        boot(3'h2, 1'b0, 2, 0);
        mem_rd_en <= 1'b1;
        exp_q.push_back({32'h0000_0000, word0});
        @(posedge core_clk);
        mem_rd_en <= 1'b0;
        boot(3'h3, 1'b0, 0, 1);
        boot(3'h6, 1'b0, 3, 2);
        boot(3'h7, 1'b0, 1, 1);
        boot(3'h1, 1'b1, 1, 0);
        for (int k = 0; k < 3; k++)
            boot(k == 0 ? 3'h0 : k == 1 ? 3'h4 : 3'h1, 1'b0, 0, 0);
        repeat (5) @(posedge core_clk);
        end_of_test();
    end
endmodule : bsl_loader_test

bind bsl_loader bsl_loader_props #(.RESET_WAIT_CYCLES(RESET_WAIT_CYCLES)) bsl_loader_props_i (.*);
